//--- hdl/error_diagnostics_reporter.sv
// Summary of operation
// RQ1: sort events into error, warning, result classes
// RQ2: error clears in-operation, fault indicator steady red
// RQ3: error clears ident ready/done bit
// RQ4: fieldbus interrupt only for coded errors
// RQ5: sensor interface fault reports 5001 codes
// RQ6: save-time disable change 5003, order 5004
// RQ7: unrestorable code reports 5005 codes
// RQ8: host link send buffer full reports 5007
// RQ9: archive fill or ack timeout reports 5007
// RQ10: fieldbus send buffer full reports 5007
// RQ11: in-operation bit0: zero in error/startup
// RQ12: run-ready bit2 only while running
// RQ13: error latched until host clears it
`timescale 1ns/100ps
`default_nettype none
`include "error_diag_consts.svh"
module error_diagnostics_reporter
  import error_diag_pkg::*;
#(
  parameter int ROM_DEPTH = 16,
  parameter int CNT_W = 8
)(
  input wire logic sys_clk_i, // 50 MHz clock
  input wire logic nrst_i, // async reset, low
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wr_data_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rd_data_o, // read data, cycle after rd_i
  input wire logic startup_done_i, // sensor functional
  input wire logic running_i, // sensor in run
  input wire logic ident_done_i, // ident job ready/done level
  input wire logic sensor_error_clear_i, // host clear pulse
  input wire logic sensor_if_fault_i, // image sensor interface fault
  input wire logic saving_i, // program save in progress
  input wire logic disable_input_i, // disable input level
  input wire logic seq_violation_i, // signal order broken
  input wire logic restore_fail_i, // stored code not restorable
  input wire logic tx_host_full_i, // tcp/serial send buffer full
  input wire logic tx_arch_full_i, // operator_archive_link buffer full
  input wire logic arch_ack_late_i, // archive server ack timeout
  input wire logic tx_fb_full_i, // fieldbus send buffer full
  input wire logic warn_evt_i, // warning message
  input wire logic result_evt_i, // read result message
  output logic in_operation_flag_o, // in operation
  output logic run_ready_o, // ready to process codes
  output logic state_fault_indicator_o, // steady red when high
  output logic ident_ready_o, // ident ready/done bit
  output logic diag_irq_o, // fieldbus diagnostics interrupt pulse
  output logic [2:0] msg_class_o, // class of last message
  output logic [15:0] fb_code_o, // fieldbus diagnostic code
  output logic [7:0] serial_code_o, // tcp/serial code
  output logic [7:0] legacy_code_o, // legacy block code
  output logic [23:0] profile_status_o // profile bytes 0,1,2
);
  // ****************************************
  // checks and types
  // ****************************************
  generate
    if (CNT_W < 1 || CNT_W > 16)
    begin : g_chk
      $error("error_diagnostics_reporter: CNT_W out of range");
    end
  endgenerate

  typedef struct packed {
    logic err;
    logic pend;
    cause_t cause;
    logic fb_att;
    logic dis_prev;
    code_word_t code;
    logic irq;
    logic in_oper;
    logic rdy;
    logic sf;
    logic ident;
    logic [2:0] cls;
    logic [CNT_W-1:0] warn_cnt;
    logic [CNT_W-1:0] res_cnt;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  code_word_t rom_q;
  logic [`EDR_NUM_CAUSES:1] ev;
  logic any_ev;
  logic clr;
  cause_t ev_cause;

  // lowest index wins when causes coincide
  function automatic cause_t pick_cause(input logic [`EDR_NUM_CAUSES:1] v);
    cause_t c;
    c = `EDR_C_NONE;
    for (int i = `EDR_NUM_CAUSES; i >= 1; i--)
    begin
      if (v[i])
        c = cause_t'(i);
    end
    return c;
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = `EDR_ZERO32;
    if (a == `EDR_ADDR_CTRL)
      d[`EDR_CTRL_FB_ATT] = s.fb_att;
    else if (a == `EDR_ADDR_STATUS)
    begin
      d[`EDR_STAT_INOPER] = s.in_oper;
      d[`EDR_STAT_ERR] = s.err;
      d[`EDR_STAT_RDY] = s.rdy;
      d[`EDR_STAT_CAUSE_LO +: 4] = s.cause;
    end
    else if (a == `EDR_ADDR_FBCODE)
      d[15:0] = s.code[`EDR_CW_FB];
    else if (a == `EDR_ADDR_HOSTCODE)
      d[15:0] = s.code[`EDR_CW_HOST];
    else if (a == `EDR_ADDR_PROFILE)
      d[23:0] = s.code[`EDR_CW_PROF];
    else if (a == `EDR_ADDR_COUNTS)
    begin
      d[CNT_W-1:0] = s.warn_cnt;
      d[16 +: CNT_W] = s.res_cnt;
    end
    return d;
  endfunction

  // ****************************************
  // cause detection
  // ****************************************
  always_comb
  begin
    // RQ5 sensor interface fault
    ev[`EDR_C_SENSOR] = sensor_if_fault_i;
    // RQ6 disable change while saving
    ev[`EDR_C_DISCHG] = saving_i && (disable_input_i != st_r.dis_prev);
    ev[`EDR_C_SEQ] = saving_i && seq_violation_i;
    // RQ7 restore failure
    ev[`EDR_C_RESTORE] = restore_fail_i;
    // RQ8 host link overflow
    ev[`EDR_C_TX_HOST] = tx_host_full_i;
    // RQ9 archive overflow or ack timeout
    ev[`EDR_C_TX_ARCH] = tx_arch_full_i;
    ev[`EDR_C_ARCH_ACK] = arch_ack_late_i;
    // RQ10 fieldbus overflow
    ev[`EDR_C_TX_FB] = tx_fb_full_i;
    any_ev = |ev;
    ev_cause = pick_cause(ev);
    clr = sensor_error_clear_i ||
          (wr_i && (addr_i == `EDR_ADDR_CTRL) && wr_data_i[`EDR_CTRL_CLEAR]);
  end

  cause_code_rom #(
    .DEPTH(ROM_DEPTH)
  ) u_rom (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .addr_i(ev_cause),
    .data_o(rom_q)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.dis_prev = disable_input_i;
    st_nxt.irq = 1'b0;
    st_nxt.pend = 1'b0;
    st_nxt.rdata = `EDR_ZERO32;
    if (wr_i && (addr_i == `EDR_ADDR_CTRL))
      st_nxt.fb_att = wr_data_i[`EDR_CTRL_FB_ATT];
    // RQ13 latch until clear, new fault beats clear
    if (any_ev && (!st_r.err || clr))
    begin
      st_nxt.err = 1'b1;
      st_nxt.pend = 1'b1;
      st_nxt.cause = ev_cause;
    end
    else if (clr)
    begin
      st_nxt.err = 1'b0;
      st_nxt.cause = `EDR_C_NONE;
      st_nxt.code = `EDR_W_NONE;
    end
    // rom answers one cycle after the cause was taken
    // a clear in that cycle must not bring the old code back
    if (st_r.pend && st_nxt.err)
    begin
      st_nxt.code = rom_q;
      // RQ4 interrupt only with a fieldbus code
      st_nxt.irq = st_r.fb_att && (rom_q[`EDR_CW_FB] != `EDR_FB_NONE);
    end
    // RQ1 class of the last message, error first
    if (any_ev)
      st_nxt.cls = CLS_ERROR;
    else if (warn_evt_i)
      st_nxt.cls = CLS_WARN;
    else if (result_evt_i)
      st_nxt.cls = CLS_RESULT;
    if (warn_evt_i)
      st_nxt.warn_cnt = st_r.warn_cnt + 1'b1;
    if (result_evt_i)
      st_nxt.res_cnt = st_r.res_cnt + 1'b1;
    // RQ2 RQ11 in-operation follows startup and error
    st_nxt.in_oper = startup_done_i && !st_nxt.err;
    st_nxt.sf = st_nxt.err;
    // RQ12 run-ready needs in-operation and run
    st_nxt.rdy = st_nxt.in_oper && running_i;
    // RQ3 ident ready/done dropped on error
    st_nxt.ident = ident_done_i && !st_nxt.err;
    if (rd_i)
      st_nxt.rdata = read_mux(st_r, addr_i);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r <= '0;
      st_r.fb_att <= `EDR_CTRL_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_data_o = st_r.rdata;
  assign in_operation_flag_o = st_r.in_oper;
  assign run_ready_o = st_r.rdy;
  assign state_fault_indicator_o = st_r.sf;
  assign ident_ready_o = st_r.ident;
  assign diag_irq_o = st_r.irq;
  assign msg_class_o = st_r.cls;
  assign fb_code_o = st_r.code[`EDR_CW_FB];
  assign serial_code_o = st_r.code[`EDR_CW_SER];
  assign legacy_code_o = st_r.code[`EDR_CW_LEG];
  assign profile_status_o = st_r.code[`EDR_CW_PROF];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence take_s(cause_t c);
    !st_r.err && any_ev && ev_cause == c;
  endsequence

  sequence report_s;
    st_r.pend ##1 st_r.err;
  endsequence

  class_one_a: assert property ($onehot0(msg_class_o)) // RQ1
    else $error("message class not unique");
  take_err_a: assert property (any_ev && (!st_r.err || clr) |=> msg_class_o == CLS_ERROR) // RQ1
    else $error("error not classed as error");
  class_warn_a: assert property (warn_evt_i && !any_ev |=> msg_class_o == CLS_WARN) // RQ1
    else $error("warning not classed as warning");
  err_inop_a: assert property ($rose(st_r.err) |-> // RQ2
    !in_operation_flag_o && state_fault_indicator_o ##1 (state_fault_indicator_o || !st_r.err))
    else $error("error did not drop in-operation or light red");
  ident_drop_a: assert property (st_r.err |-> !ident_ready_o) // RQ3
    else $error("ident ready held during error");
  irq_gate_a: assert property (diag_irq_o |-> $past(st_r.fb_att) && fb_code_o != `EDR_FB_NONE) // RQ4
    else $error("interrupt without fieldbus code");
  irq_fire_a: assert property (!st_r.err && any_ev ##1 st_r.fb_att && !clr |=> diag_irq_o) // RQ4
    else $error("coded error raised no interrupt");
  sensor_code_a: assert property (take_s(`EDR_C_SENSOR) ##1 report_s |-> // RQ5
    fb_code_o == `EDR_FB_SENSOR && profile_status_o == 24'hE1_FE02)
    else $error("sensor fault code wrong");
  save_code_a: assert property ((take_s(`EDR_C_DISCHG) or take_s(`EDR_C_SEQ)) ##1 report_s |-> // RQ6
    legacy_code_o == 8'h02 && profile_status_o == 24'hE6_FE04)
    else $error("save error code wrong");
  restore_code_a: assert property (take_s(`EDR_C_RESTORE) ##1 report_s |-> // RQ7
    fb_code_o == `EDR_FB_RESTORE && legacy_code_o == 8'h04)
    else $error("restore code wrong");
  host_tx_a: assert property (take_s(`EDR_C_TX_HOST) ##1 report_s |-> // RQ8
    fb_code_o == `EDR_FB_TX && legacy_code_o == 8'h0A)
    else $error("host transfer code wrong");
  arch_tx_a: assert property ((take_s(`EDR_C_TX_ARCH) or take_s(`EDR_C_ARCH_ACK)) ##1 report_s |-> // RQ9
    fb_code_o == `EDR_FB_TX && serial_code_o == 8'h07)
    else $error("archive transfer code wrong");
  fb_tx_a: assert property (take_s(`EDR_C_TX_FB) ##1 report_s |-> // RQ10
    fb_code_o == `EDR_FB_TX && profile_status_o == 24'hE1_FE04)
    else $error("fieldbus transfer code wrong");
  run_drop_a: assert property (!running_i |=> !run_ready_o) // RQ12
    else $error("run-ready while not running");
  clear_drop_a: assert property (clr && !any_ev |=> !st_r.err && fb_code_o == `EDR_FB_NONE) // RQ13
    else $error("clear did not drop the error");
  inop_start_a: assert property (!$past(startup_done_i) |-> !in_operation_flag_o) // RQ11
    else $error("in-operation during startup");
  run_ready_a: assert property (run_ready_o |-> in_operation_flag_o && $past(running_i)) // RQ12
    else $error("run-ready without run");
  err_latch_a: assert property (st_r.err && !clr |=> st_r.err && $stable(st_r.cause)) // RQ13
    else $error("error released without clear");
endmodule
`default_nettype wire

//--- hdl/error_diag_consts.svh
`ifndef ERROR_DIAG_CONSTS_SVH
`define ERROR_DIAG_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define EDR_ADDR_CTRL 8'h00
`define EDR_ADDR_STATUS 8'h04
`define EDR_ADDR_FBCODE 8'h08
`define EDR_ADDR_HOSTCODE 8'h0C
`define EDR_ADDR_PROFILE 8'h10
`define EDR_ADDR_COUNTS 8'h14

// ****************************************
// field positions
// ****************************************
`define EDR_CTRL_FB_ATT 0
`define EDR_CTRL_CLEAR 1
`define EDR_STAT_INOPER 0
`define EDR_STAT_ERR 1
`define EDR_STAT_RDY 2
`define EDR_STAT_CAUSE_LO 4
`define EDR_CTRL_RESET 1'h0
`define EDR_ZERO32 32'h0000_0000

// ****************************************
// cause indices, lowest wins
// ****************************************
`define EDR_C_NONE 4'h0
`define EDR_C_SENSOR 4'h1
`define EDR_C_DISCHG 4'h2
`define EDR_C_SEQ 4'h3
`define EDR_C_RESTORE 4'h4
`define EDR_C_TX_HOST 4'h5
`define EDR_C_TX_ARCH 4'h6
`define EDR_C_ARCH_ACK 4'h7
`define EDR_C_TX_FB 4'h8
`define EDR_NUM_CAUSES 8

// ****************************************
// code words {fieldbus, serial, legacy, p0, p1, p2}
// ****************************************
`define EDR_FB_SENSOR 16'h5001
`define EDR_FB_DISCHG 16'h5003
`define EDR_FB_SEQ 16'h5004
`define EDR_FB_RESTORE 16'h5005
`define EDR_FB_TX 16'h5007
`define EDR_W_SENSOR {16'h5001, 8'h01, 8'h01, 8'hE1, 8'hFE, 8'h02}
`define EDR_W_DISCHG {16'h5003, 8'h03, 8'h02, 8'hE6, 8'hFE, 8'h04}
`define EDR_W_SEQ {16'h5004, 8'h04, 8'h02, 8'hE6, 8'hFE, 8'h04}
`define EDR_W_RESTORE {16'h5005, 8'h05, 8'h04, 8'hE1, 8'hFE, 8'h06}
`define EDR_W_TX {16'h5007, 8'h07, 8'h0A, 8'hE1, 8'hFE, 8'h04}
`define EDR_W_NONE 56'h00_0000_0000_0000
`define EDR_FB_NONE 16'h0000

// ****************************************
// fields of a code word
// ****************************************
`define EDR_CW_FB 55:40
`define EDR_CW_SER 39:32
`define EDR_CW_LEG 31:24
`define EDR_CW_HOST 39:24
`define EDR_CW_PROF 23:0

`endif

//--- hdl/error_diag_pkg.sv
package error_diag_pkg;
  typedef logic [3:0] cause_t;
  typedef logic [55:0] code_word_t;
  typedef enum logic [2:0] {
    CLS_ERROR = 3'b001,
    CLS_WARN = 3'b010,
    CLS_RESULT = 3'b100
  } msg_class_t;
endpackage

//--- hdl/cause_code_rom.sv
`timescale 1ns/100ps
`default_nettype none
`include "error_diag_consts.svh"
module cause_code_rom
  import error_diag_pkg::*;
#(
  parameter int DEPTH = 16
)(
  input wire logic sys_clk_i, // system clock
  input wire logic nrst_i, // async reset, low
  input wire cause_t addr_i, // cause index
  output logic [55:0] data_o // registered code word
);
  // ****************************************
  // table of codes per cause
  // ****************************************
  generate
    if (DEPTH < `EDR_NUM_CAUSES + 1)
    begin : g_chk
      $error("cause_code_rom: DEPTH too small");
    end
  endgenerate

  code_word_t word;

  always_comb
  begin
    case (addr_i)
      `EDR_C_SENSOR: word = `EDR_W_SENSOR;
      `EDR_C_DISCHG: word = `EDR_W_DISCHG;
      `EDR_C_SEQ: word = `EDR_W_SEQ;
      `EDR_C_RESTORE: word = `EDR_W_RESTORE;
      // host link, archive fill, archive ack and fieldbus fill share one code
      `EDR_C_TX_HOST, `EDR_C_TX_ARCH, `EDR_C_ARCH_ACK, `EDR_C_TX_FB: word = `EDR_W_TX;
      default: word = `EDR_W_NONE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      data_o <= `EDR_W_NONE;
    else
      data_o <= word;
  end
endmodule
`default_nettype wire

//--- verif/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic sys_clk_i, // clock
  input wire logic nrst_i, // reset, low
  input wire logic diag_irq_i, // interrupt from reader
  input wire logic [3:0] delay_i, // reaction time, cycles
  output logic clear_o, // sensor_error_clear pulse
  output var int irq_cnt_o // interrupts seen
);
  int wait_r;
  // host clears only after it saw the interrupt
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      clear_o <= 1'b0;
      wait_r <= -1;
      irq_cnt_o <= 0;
    end
    else
    begin
      clear_o <= (wait_r == 0);
      wait_r <= diag_irq_i ? int'(delay_i) : ((wait_r >= 0) ? wait_r - 1 : -1);
      irq_cnt_o <= irq_cnt_o + int'(diag_irq_i);
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import error_diag_pkg::*;
  logic sys_clk_i, nrst_i, wr_i, rd_i, startup_done_i, running_i, ident_done_i, clr;
  logic saving_i, disable_input_i, warn_evt_i, result_evt_i, in_oper, rdy, sf, idr, irq;
  logic [7:0] addr_i, m, ser, leg;
  logic [31:0] wr_data_i, rd_data_o, rv;
  logic [8:1] cz;
  logic [2:0] cls;
  logic [15:0] fb;
  logic [23:0] prof;
  logic [3:0] dly;
  int bad_count, compares, seed, n_irq, irqs, lo;

  error_diagnostics_reporter dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .startup_done_i(startup_done_i), .running_i(running_i), .ident_done_i(ident_done_i),
    .sensor_error_clear_i(clr), .sensor_if_fault_i(cz[1]), .saving_i(saving_i),
    .disable_input_i(disable_input_i), .seq_violation_i(cz[3]), .restore_fail_i(cz[4]),
    .tx_host_full_i(cz[5]), .tx_arch_full_i(cz[6]), .arch_ack_late_i(cz[7]),
    .tx_fb_full_i(cz[8]), .warn_evt_i(warn_evt_i), .result_evt_i(result_evt_i),
    .in_operation_flag_o(in_oper), .run_ready_o(rdy), .state_fault_indicator_o(sf),
    .ident_ready_o(idr), .diag_irq_o(irq), .msg_class_o(cls), .fb_code_o(fb),
    .serial_code_o(ser), .legacy_code_o(leg), .profile_status_o(prof));

  host_model host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .diag_irq_i(irq),
    .delay_i(dly), .clear_o(clr), .irq_cnt_o(irqs));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic tally(input logic ok);
    compares++;
    if (!ok)
    begin
      bad_count++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask

  task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp);
  endtask

  task automatic chk_code(input logic [55:0] got, input logic [55:0] exp);
    tally(got === exp);
  endtask

  function automatic logic [55:0] exp_code(input int c);
    case (c)
      1: return 56'h50_0101_01E1_FE02;
      2: return 56'h50_0303_02E6_FE04;
      3: return 56'h50_0404_02E6_FE04;
      4: return 56'h50_0505_04E1_FE06;
      default: return 56'h50_0707_0AE1_FE04;
    endcase
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic fire(input logic [8:1] mk, input logic [1:0] ev);
    @(posedge sys_clk_i);
    cz <= mk;
    disable_input_i <= disable_input_i ^ mk[2];
    {result_evt_i, warn_evt_i} <= ev;
    @(posedge sys_clk_i);
    cz <= '0;
    {result_evt_i, warn_evt_i} <= 2'b00;
    #1;
  endtask

  // ****************************************
  // one error from raise to clear
  // ****************************************
  task automatic err_case(input logic [8:1] mk, input int c, input logic att);
    logic [55:0] e;
    e = exp_code(c);
    reg_wr(8'h00, {31'h0, att});
    n_irq += int'(att);
    fire(mk, 2'b01);
    chk_bits({in_oper, sf, idr, rdy, 1'b0, cls}, 8'h41);
    @(posedge sys_clk_i);
    #1;
    chk_code({fb, ser, leg, prof}, exp_code(c));
    chk_bits({7'h0, irq}, {7'h0, att});
    // a second cause while latched must leave the first one standing
    fire(8'h01, 2'b00);
    @(posedge sys_clk_i);
    #1;
    chk_code({fb, ser, leg, prof}, exp_code(c));
    chk_bits({7'h0, irq}, 8'h00);
    reg_rd(8'h08, rv);
    chk_code({40'h0, rv[15:0]}, {40'h0, e[55:40]});
    reg_rd(8'h0C, rv);
    chk_code({40'h0, rv[15:0]}, {40'h0, e[39:24]});
    reg_rd(8'h10, rv);
    chk_code({32'h0, rv[23:0]}, {32'h0, e[23:0]});
    reg_rd(8'h04, rv);
    chk_bits({rv[7:4], 1'b0, rv[2:0]}, {c[3:0], 4'b0010});
    if (!att)
      reg_wr(8'h00, 32'h0000_0002);
    for (int i = 0; i < 30 && sf !== 1'b0; i++)
    begin
      @(posedge sys_clk_i);
      #1;
    end
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk_code({fb, ser, leg, prof}, 56'h0);
    chk_bits({4'h0, in_oper, sf, idr, rdy}, {5'h1, 1'b0, ident_done_i, running_i});
  endtask

  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge sys_clk_i);
    bad_count++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 32;
    {nrst_i, wr_i, rd_i, startup_done_i, running_i, ident_done_i} = '0;
    {saving_i, disable_input_i, warn_evt_i, result_evt_i, addr_i, wr_data_i, cz} = '0;
    dly = 4'h8;
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk_bits({in_oper, sf, irq, 2'b0, cls}, 8'h00);
    reg_rd(8'h00, rv);
    chk_code({24'h0, rv}, 56'h0);
    reg_rd(8'h18, rv);
    chk_code({24'h0, rv}, 56'h0);
    @(posedge sys_clk_i);
    startup_done_i <= 1'b1;
    fire(8'h06, 2'b10);
    chk_bits({sf, 4'h0, cls}, 8'h04);
    fire(8'h00, 2'b11);
    chk_bits({sf, 4'h0, cls}, 8'h02);
    reg_rd(8'h14, rv);
    chk_bits(rv[7:0], 8'h01);
    chk_bits(rv[23:16], 8'h02);
    @(posedge sys_clk_i);
    saving_i <= 1'b1;
    for (int c = 1; c <= 8; c++)
    begin
      {running_i, ident_done_i} <= 2'($random(seed));
      dly <= 4'($random(seed)) | 4'h8;
      err_case(8'(1 << (c - 1)), c, 1'b1);
    end
    err_case(8'hA4, 3, 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      m = 8'($random(seed)) | 8'h80;
      {running_i, ident_done_i} <= 2'($random(seed));
      for (int b = 8; b >= 1; b--)
        if (m[b - 1])
          lo = b;
      err_case(m, lo, 1'($random(seed)));
    end
    chk_bits(8'(irqs), 8'(n_irq));
    err_case(8'h10, 5, 1'b0);
    chk_bits(8'(irqs), 8'(n_irq));
    close_out();
  end
endmodule
`default_nettype wire
